// ==== rtl/cmp1r_pkg.sv ====
// package: register addresses, field positions, reset values and codes for the comparator regs
package cmp1r_pkg;
    // special function register addresses
    localparam logic [7:0] CMP1R_CTRL_ADDR = 8'h9a;
    localparam logic [7:0] CMP1R_MODE_ADDR = 8'h9c;
    localparam logic [7:0] CMP1R_SEL_ADDR  = 8'h9f;
    // reset values
    localparam logic [7:0] CMP1R_CTRL_RST  = 8'h00;
    localparam logic [7:0] CMP1R_MODE_RST  = 8'h02;
    localparam logic [7:0] CMP1R_SEL_RST   = 8'h00;
    // control register field positions
    localparam int CMP1R_ON_BIT     = 7;
    localparam int CMP1R_RESULT_BIT = 6;
    localparam int CMP1R_RISE_BIT   = 5;
    localparam int CMP1R_FALL_BIT   = 4;
    localparam int CMP1R_HYP_LSB    = 2;
    localparam int CMP1R_HYN_LSB    = 0;
    // mode register field positions
    localparam int CMP1R_RIE_BIT    = 5;
    localparam int CMP1R_FIE_BIT    = 4;
    localparam int CMP1R_SPEED_LSB  = 0;
    // input select field positions
    localparam int CMP1R_NSEL_LSB   = 4;
    localparam int CMP1R_PSEL_LSB   = 0;
    // writable masks; unused pairs stay zero
    localparam logic [7:0] CMP1R_MODE_MASK = 8'h33;
    localparam logic [7:0] CMP1R_SEL_MASK  = 8'h33;
    // hysteresis amount codes
    typedef enum logic [1:0] {
        CMP1R_HYS_OFF = 2'b00,
        CMP1R_HYS_5MV = 2'b01,
        CMP1R_HYS_10MV = 2'b10,
        CMP1R_HYS_20MV = 2'b11
    } cmp1r_hys_t;
    // response speed codes
    typedef enum logic [1:0] {
        CMP1R_SPD_FAST = 2'b00,
        CMP1R_SPD_MID1 = 2'b01,
        CMP1R_SPD_MID2 = 2'b10,
        CMP1R_SPD_LOWP = 2'b11
    } cmp1r_speed_t;
endpackage : cmp1r_pkg

// ==== rtl/cmp1r_sync.sv ====
// two-flop synchroniser with edge detection for the raw comparator output
`timescale 1ns/1ps
module cmp1r_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // raw asynchronous level
    input  wire logic async_in,
    // synchronised level and edge pulses
    output logic      level,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic meta_reg;     // first stage, read only by second stage
    logic meta_next;
    logic sync_reg;     // second stage
    logic sync_next;
    logic prev_reg;     // delayed copy for edges
    logic prev_next;

    // next values of the chain
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // register stage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // one pulse per settled transition
    assign level      = sync_reg;
    assign rise_pulse = sync_reg & ~prev_reg;
    assign fall_pulse = ~sync_reg & prev_reg;
endmodule : cmp1r_sync

// ==== rtl/cmp1r_regs.sv ====
// control, input select and mode register bank for the second comparator
`timescale 1ns/1ps
//
// Contract
// - enable bit seven powers comparator, output valid
// - bit six reads comparator result, read-only
// - rising output edge sets rise flag
// - falling output edge sets fall flag
// - positive hysteresis code: off,5,10,20 mV
// - negative hysteresis code: off,5,10,20 mV
// - negative input selects one of four pins
// - positive input selects one of four pins
// - unused bit pairs read zero, ignore writes
// - rise interrupt only with rise enable
// - fall interrupt only with fall enable
// - mode code sets response speed versus power
// - edge flags stay set until software clears
// - disabled comparator output drives logic low
module cmp1r_regs
    import cmp1r_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // special function register port
    input  wire logic [7:0]        sfr_addr,
    input  wire logic [7:0]        sfr_wdata,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    output logic      [7:0]        sfr_rdata,
    // analog comparator raw result
    input  wire logic              cmp_raw,
    // analog controls
    output logic                   cmp_on,
    output cmp1r_pkg::cmp1r_hys_t  pos_hysteresis_code,
    output cmp1r_pkg::cmp1r_hys_t  neg_hysteresis_code,
    output cmp1r_pkg::cmp1r_speed_t response_speed_code,
    output logic      [1:0]        pos_input_select,
    output logic      [1:0]        neg_input_select,
    // digital results
    output logic                   cmp_port_out,
    output logic                   cmp_irq
);
    import cmp1r_pkg::*;

    // write strobe decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    logic       on_reg;          // enable
    logic       on_next;
    logic       rise_reg;        // rise_event_flag
    logic       rise_next;
    logic       fall_reg;        // fall_event_flag
    logic       fall_next;
    logic [1:0] hyp_reg;         // positive hysteresis
    logic [1:0] hyp_next;
    logic [1:0] hyn_reg;         // negative hysteresis
    logic [1:0] hyn_next;
    logic [7:0] mode_reg;        // masked mode register
    logic [7:0] mode_next;
    logic [7:0] sel_reg;         // masked input select
    logic [7:0] sel_next;
    logic [7:0] rdata_reg;       // read data
    logic [7:0] rdata_next;
    logic       port_reg;        // port pin copy
    logic       port_next;
    logic       irq_reg;         // interrupt request
    logic       irq_next;
    logic       cmp_result;      // synchronised result
    logic       rise_pulse;
    logic       fall_pulse;
    logic       wr_ctrl;
    logic [7:0] ctrl_view;       // control register as read

    // synchroniser for the asynchronous analog output
    cmp1r_sync u_sync (
        .clock      (clock),
        .rst_n      (rst_n),
        .async_in   (cmp_raw & on_reg),
        .level      (cmp_result),
        .rise_pulse (rise_pulse),
        .fall_pulse (fall_pulse)
    );

    assign wr_ctrl = sfr_wr & hit(sfr_addr, CMP1R_CTRL_ADDR);

    // control register read view
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[CMP1R_ON_BIT]     = on_reg;
        ctrl_view[CMP1R_RESULT_BIT] = cmp_result;
        ctrl_view[CMP1R_RISE_BIT]   = rise_reg;
        ctrl_view[CMP1R_FALL_BIT]   = fall_reg;
        ctrl_view[CMP1R_HYP_LSB+:2] = hyp_reg;
        ctrl_view[CMP1R_HYN_LSB+:2] = hyn_reg;
    end

    // next register state
    always_comb begin
        on_next    = on_reg;
        hyp_next   = hyp_reg;
        hyn_next   = hyn_reg;
        rise_next  = rise_reg;
        fall_next  = fall_reg;
        mode_next  = mode_reg;
        sel_next   = sel_reg;
        // software writes; result bit ignored
        if (wr_ctrl) begin
            on_next   = sfr_wdata[CMP1R_ON_BIT];
            hyp_next  = sfr_wdata[CMP1R_HYP_LSB+:2];
            hyn_next  = sfr_wdata[CMP1R_HYN_LSB+:2];
            rise_next = sfr_wdata[CMP1R_RISE_BIT];
            fall_next = sfr_wdata[CMP1R_FALL_BIT];
        end
        if (sfr_wr && hit(sfr_addr, CMP1R_MODE_ADDR)) begin
            mode_next = sfr_wdata & CMP1R_MODE_MASK;
        end
        if (sfr_wr && hit(sfr_addr, CMP1R_SEL_ADDR)) begin
            sel_next = sfr_wdata & CMP1R_SEL_MASK;
        end
        // hardware set wins over a clearing write; flags sticky
        if (rise_pulse) begin
            rise_next = 1'b1;
        end
        if (fall_pulse) begin
            fall_next = 1'b1;
        end
        // read mux; unmapped address reads zero
        case (sfr_addr)
            CMP1R_CTRL_ADDR: rdata_next = ctrl_view;
            CMP1R_MODE_ADDR: rdata_next = mode_reg;
            CMP1R_SEL_ADDR:  rdata_next = sel_reg;
            default:         rdata_next = 8'h00;
        endcase
        if (!sfr_rd) begin
            rdata_next = rdata_reg;
        end
        // port copy is low when disabled
        port_next = on_reg & cmp_result;
        // interrupt from enabled flags
        irq_next = (rise_next & mode_next[CMP1R_RIE_BIT])
                 | (fall_next & mode_next[CMP1R_FIE_BIT]);
    end

    // register stage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            on_reg    <= CMP1R_CTRL_RST[CMP1R_ON_BIT];
            rise_reg  <= CMP1R_CTRL_RST[CMP1R_RISE_BIT];
            fall_reg  <= CMP1R_CTRL_RST[CMP1R_FALL_BIT];
            hyp_reg   <= CMP1R_CTRL_RST[CMP1R_HYP_LSB+:2];
            hyn_reg   <= CMP1R_CTRL_RST[CMP1R_HYN_LSB+:2];
            mode_reg  <= CMP1R_MODE_RST;
            sel_reg   <= CMP1R_SEL_RST;
            rdata_reg <= 8'h00;
            port_reg  <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            on_reg    <= on_next;
            rise_reg  <= rise_next;
            fall_reg  <= fall_next;
            hyp_reg   <= hyp_next;
            hyn_reg   <= hyn_next;
            mode_reg  <= mode_next;
            sel_reg   <= sel_next;
            rdata_reg <= rdata_next;
            port_reg  <= port_next;
            irq_reg   <= irq_next;
        end
    end

    // outputs straight from flops
    assign sfr_rdata           = rdata_reg;
    assign cmp_on              = on_reg;
    assign pos_hysteresis_code = cmp1r_hys_t'(hyp_reg);
    assign neg_hysteresis_code = cmp1r_hys_t'(hyn_reg);
    assign response_speed_code = cmp1r_speed_t'(mode_reg[CMP1R_SPEED_LSB+:2]);
    assign neg_input_select    = sel_reg[CMP1R_NSEL_LSB+:2];
    assign pos_input_select    = sel_reg[CMP1R_PSEL_LSB+:2];
    assign cmp_port_out        = port_reg;
    assign cmp_irq             = irq_reg;

    // rise edge sets flag next cycle
    sequence rise_seen_s;
        rise_pulse;
    endsequence
    rise_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise_seen_s |=> rise_reg) else $error("rise flag not set");
    fall_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        fall_pulse |=> fall_reg) else $error("fall flag not set");
    flag_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise_reg && !wr_ctrl |=> rise_reg) else $error("rise flag dropped");
    port_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        !on_reg |=> !cmp_port_out) else $error("port high while off");
    unused_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        ((mode_reg & ~CMP1R_MODE_MASK) == 8'h00) && ((sel_reg & ~CMP1R_SEL_MASK) == 8'h00))
        else $error("unused bits set");
    irq_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmp_irq && !fall_reg |-> mode_reg[CMP1R_RIE_BIT]) else $error("rise irq unmasked");
    irq_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmp_irq && !rise_reg |-> mode_reg[CMP1R_FIE_BIT]) else $error("fall irq unmasked");
    irq_form_a: assert property (@(posedge clock) disable iff (!rst_n)
        cmp_irq == ((rise_reg & mode_reg[CMP1R_RIE_BIT]) | (fall_reg & mode_reg[CMP1R_FIE_BIT])))
        else $error("irq mismatch");
    on_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctrl |=> cmp_on == $past(sfr_wdata[CMP1R_ON_BIT])) else $error("enable not written");
    // fall flag holds like the rise flag
    fall_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
        fall_reg && !wr_ctrl |=> fall_reg) else $error("fall flag dropped");
    // result bit reads back the synchronised level
    result_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        sfr_rd && hit(sfr_addr, CMP1R_CTRL_ADDR)
        |=> sfr_rdata[CMP1R_RESULT_BIT] == $past(cmp_result))
        else $error("result bit misread");
    // mode write reaches the response speed output
    speed_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        sfr_wr && hit(sfr_addr, CMP1R_MODE_ADDR)
        |=> response_speed_code == $past(sfr_wdata[CMP1R_SPEED_LSB+:2]))
        else $error("speed code not written");
    // select write reaches the negative input mux
    nsel_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        sfr_wr && hit(sfr_addr, CMP1R_SEL_ADDR)
        |=> neg_input_select == $past(sfr_wdata[CMP1R_NSEL_LSB+:2]))
        else $error("negative select not written");
    // one settled transition gives a single pulse
    pulse_once_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise_pulse |=> !rise_pulse) else $error("rise pulse repeated");
endmodule : cmp1r_regs

// ==== dv/testbench.sv ====
// self-checking bench for the comparator register bank, against a behavioural model
`timescale 1ns/1ps
module testbench;
    import cmp1r_pkg::*;
    // clock, reset and register port stimulus
    logic         clock     = 1'b0;
    logic         rst_n     = 1'b0;
    logic [7:0]   sfr_addr  = 8'h00;
    logic [7:0]   sfr_wdata = 8'h00;
    logic         sfr_wr    = 1'b0;
    logic         sfr_rd    = 1'b0;
    logic         cmp_raw   = 1'b0;
    // design outputs
    logic [7:0]   sfr_rdata;
    logic         cmp_on;
    cmp1r_hys_t   pos_hysteresis_code;
    cmp1r_hys_t   neg_hysteresis_code;
    cmp1r_speed_t response_speed_code;
    logic [1:0]   pos_input_select;
    logic [1:0]   neg_input_select;
    logic         cmp_port_out;
    logic         cmp_irq;
    // model state and bookkeeping
    logic [7:0]   m_ctrl, m_mode, m_sel;   // model registers, result bit kept apart
    logic         m_res;                   // model of the synchronised gated result
    int           mismatches = 0;
    int           n_compared = 0;
    int           cycles     = 0;
    int           seed       = 32'h0000_2df6;
    logic [7:0]   addrs [4];               // mapped places plus one unmapped
    cmp1r_regs dut (
        .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw),
        .cmp_on(cmp_on), .pos_hysteresis_code(pos_hysteresis_code),
        .neg_hysteresis_code(neg_hysteresis_code), .response_speed_code(response_speed_code),
        .pos_input_select(pos_input_select), .neg_input_select(neg_input_select),
        .cmp_port_out(cmp_port_out), .cmp_irq(cmp_irq));
    // free-running 50 MHz clock
    always #10 clock = ~clock;
    // hang guard, far above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end
    // verdict and end of run
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one comparison, reported at once on mismatch
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // model back to its reset values
    task automatic model_rst();
        m_ctrl = CMP1R_CTRL_RST;
        m_mode = CMP1R_MODE_RST;
        m_sel  = CMP1R_SEL_RST;
        m_res  = 1'b0;
    endtask
    // expected read data per address
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            CMP1R_CTRL_ADDR: return m_ctrl | {1'b0, m_res, 6'h00};
            CMP1R_MODE_ADDR: return m_mode;
            CMP1R_SEL_ADDR:  return m_sel;
            default:         return 8'h00;
        endcase
    endfunction
    // single write, strobe held so writes may follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_rd = 1'b0;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clock);
        #1;
        if (a == CMP1R_CTRL_ADDR) m_ctrl = d & 8'hbf;
        if (a == CMP1R_MODE_ADDR) m_mode = d & 8'h33;
        if (a == CMP1R_SEL_ADDR) m_sel = d & 8'h33;
    endtask
    // single read, data registered on the taking edge
    task automatic rd(input logic [7:0] a);
        sfr_wr = 1'b0;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clock);
        #1;
        cmp8(sfr_rdata, exp_rd(a));
    endtask
    // let the synchroniser settle, update model edges, compare ports and registers
    task automatic chk();
        logic nres;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        nres = m_ctrl[7] & cmp_raw;
        if (nres && !m_res) m_ctrl[5] = 1'b1;
        if (!nres && m_res) m_ctrl[4] = 1'b1;
        m_res = nres;
        cmp8({7'h00, cmp_on}, {7'h00, m_ctrl[7]});
        cmp8({6'h00, pos_hysteresis_code}, {6'h00, m_ctrl[3:2]});
        cmp8({6'h00, neg_hysteresis_code}, {6'h00, m_ctrl[1:0]});
        cmp8({6'h00, neg_input_select}, {6'h00, m_sel[5:4]});
        cmp8({6'h00, pos_input_select}, {6'h00, m_sel[1:0]});
        cmp8({6'h00, response_speed_code}, {6'h00, m_mode[1:0]});
        cmp8({7'h00, cmp_port_out}, {7'h00, m_res});
        cmp8({7'h00, cmp_irq}, {7'h00, (m_ctrl[5] & m_mode[5]) | (m_ctrl[4] & m_mode[4])});
        for (int i = 0; i < 4; i++) rd(addrs[i]);
    endtask
    // main sequence
    initial begin
        logic [1:0] c;
        addrs = '{CMP1R_CTRL_ADDR, CMP1R_MODE_ADDR, CMP1R_SEL_ADDR, 8'h9b};
        model_rst();
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk();
        // every hysteresis, select and speed code, writes back to back
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(CMP1R_CTRL_ADDR, {4'h0, c, c});
            wr(CMP1R_MODE_ADDR, {6'h00, c});
            wr(CMP1R_SEL_ADDR, {2'b11, c, 2'b11, c});
            chk();
        end
        // enable, rise with interrupt, clear while high, disable gives fall
        wr(CMP1R_MODE_ADDR, 8'hff);
        wr(CMP1R_CTRL_ADDR, 8'hc0);
        chk();
        cmp_raw = 1'b1;
        chk();
        wr(CMP1R_CTRL_ADDR, 8'h80);
        chk();
        wr(CMP1R_MODE_ADDR, 8'h10);
        wr(CMP1R_CTRL_ADDR, 8'h00);
        chk();
        // random traffic with an occasional reset in mid-run
        for (int n = 0; n < 120; n++) begin
            cmp_raw = 1'($random(seed));
            chk();
            wr(addrs[$random(seed) & 3], 8'($random(seed)));
            if (($random(seed) & 15) == 0) begin
                sfr_wr = 1'b0;
                rst_n = 1'b0;
                repeat (2) @(posedge clock);
                #1;
                rst_n = 1'b1;
                model_rst();
            end
            chk();
        end
        close_out();
    end
endmodule // testbench
